// [pkg/scc_cfg.svh]
// Register offsets, field positions, reset values and timing counts
// Function
// - Idle-stop 1 halts channel in Idle
// - Direction 1 receive, 0 transmit
// - Checksum enable verifies or computes CRC
// - Polarity 1 idles low, 0 high, ignored when receiving
// - Short PWM enable ignored when transmitting
// - Unused bits read zero, ignore writes
`ifndef SCC_CFG_SVH
`define SCC_CFG_SVH
`define SCC_OFS_CON1 4'h0
`define SCC_OFS_DATA 4'h4
`define SCC_OFS_STAT 4'h8
`define SCC_BIT_EN 15
`define SCC_BIT_SIDL 13
`define SCC_BIT_RCV 11
`define SCC_BIT_TXM 10
`define SCC_BIT_POL 9
`define SCC_BIT_CRC 8
`define SCC_BIT_PPP 7
`define SCC_BIT_SPC 6
`define SCC_BIT_PS 4
`define SCC_CON1_MASK 16'hAFD7
`define SCC_CON1_RST 16'h0000
`define SCC_TICK_NS 1000
`define SCC_CLK_NS 25
`define SCC_TICK_CYC ((`SCC_TICK_NS + `SCC_CLK_NS - 1) / `SCC_CLK_NS)
`define SCC_CRC_SEED 4'h5
`endif

// [pkg/scc_pkg.sv]
// Types shared by the channel control block
package scc_pkg;
    typedef logic [15:0] scc_word_t;
    typedef enum logic [1:0] {
        SCC_TX_IDLE,
        SCC_TX_NIB,
        SCC_TX_LOW
    } scc_txst_e;
endpackage

// [hw/scc_skid.sv]
// Two-entry buffer with valid and ready on both sides
module scc_skid #(
    parameter int WIDTH = 16
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Fill side
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    // Drain side
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    logic [WIDTH-1:0] mem_reg [2];
    logic wp_reg;
    logic rp_reg;
    logic [1:0] cnt_reg;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;
    assign in_ready = (cnt_reg != 2'h2);
    assign out_valid = (cnt_reg != 2'h0);
    assign out_data = mem_reg[rp_reg];
    initial begin
        if (WIDTH < 1) $error("scc_skid: WIDTH must be positive");
    end
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wp_reg <= 1'b0;
            rp_reg <= 1'b0;
            cnt_reg <= 2'h0;
        end else begin
            if (push) begin
                mem_reg[wp_reg] <= in_data;
                wp_reg <= ~wp_reg;
            end
            if (pop) rp_reg <= ~rp_reg;
            cnt_reg <= cnt_reg + {1'b0, push} - {1'b0, pop};
        end
    end
endmodule // scc_skid

// [hw/scc_channel.sv]
// SENT channel control register and simple nibble transmitter/receiver
//
// The placing of the registers and the Avalon-MM register port were decided locally.
`include "scc_cfg.svh"
module scc_channel #(
    parameter int TICK_CYC = `SCC_TICK_CYC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Avalon-MM slave
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Device state
    input wire logic idle_mode,
    input wire logic spc_trigger,
    // Link pin
    input wire logic sent_in,
    output logic sent_out,
    // Received words
    output logic [15:0] rx_data,
    output logic rx_valid,
    input wire logic rx_ready,
    output logic crc_error
);
    import scc_pkg::*;
    initial begin
        if (TICK_CYC < 1) $error("scc_channel: TICK_CYC must be >= 1");
    end
    scc_word_t con_reg;
    scc_word_t tx_word_reg;
    logic tx_go_reg;
    logic [31:0] rdata_reg;
    logic ack_reg;
    logic wait_reg;
    logic out_reg;
    logic s1_reg, s2_reg, s3_reg;
    logic [15:0] tick_reg;
    logic [1:0] pre_reg;
    scc_txst_e st_reg;
    logic [4:0] nib_reg;
    logic rec_reg;
    logic [19:0] sh_reg;
    logic [4:0] rxn_reg;
    logic [19:0] rxsh_reg;
    logic rxpush_reg;
    logic crcerr_reg;
    logic sp1_reg, sp2_reg, sp3_reg;
    logic rxarm_reg;
    logic [15:0] rxd_reg;
    logic buf_rdy;
    logic [15:0] buf_data;
    logic buf_valid;

    // Address decode
    wire sel_con = (avs_address == `SCC_OFS_CON1);
    wire sel_dat = (avs_address == `SCC_OFS_DATA);
    wire sel_sta = (avs_address == `SCC_OFS_STAT);
    wire req = (avs_read || avs_write) && !ack_reg;
    wire wr_con = req && avs_write && sel_con;
    wire wr_dat = req && avs_write && sel_dat;
    wire enable = con_reg[`SCC_BIT_EN];
    wire run = enable && !(idle_mode && con_reg[`SCC_BIT_SIDL]);
    wire rx_mode = con_reg[`SCC_BIT_RCV];
    wire txm_eff = con_reg[`SCC_BIT_TXM] && !rx_mode;
    wire pol_eff = con_reg[`SCC_BIT_POL] && !rx_mode;
    wire spc_eff = con_reg[`SCC_BIT_SPC] && rx_mode;
    wire crc_on = con_reg[`SCC_BIT_CRC];
    wire [1:0] pre_max = con_reg[`SCC_BIT_PS] ? 2'h3 : 2'h0;
    wire tick = run && (tick_reg == 16'h0) && (pre_reg == 2'h0);
    wire idle_lvl = ~pol_eff;
    wire [31:0] rd_mux = sel_con ? {16'h0000, con_reg} :
        sel_dat ? {16'h0000, tx_word_reg} :
        sel_sta ? {28'h0000000, crcerr_reg, buf_valid, tx_go_reg,
            st_reg != SCC_TX_IDLE} : 32'h00000000;
    // Edge of the synchronised trigger pin
    wire spc_edge = sp2_reg && !sp3_reg;
    wire tx_start = run && !rx_mode && st_reg == SCC_TX_IDLE &&
        (txm_eff ? tx_go_reg : 1'b1);
    wire [3:0] tx_ck = `SCC_CRC_SEED ^ tx_word_reg[15:12] ^
        tx_word_reg[11:8] ^ tx_word_reg[7:4] ^ tx_word_reg[3:0];
    // Receiver: bit cell is marker, data, recovery, one tick each
    wire [15:0] rx_per = con_reg[`SCC_BIT_PS] ? 16'(TICK_CYC * 4) :
        16'(TICK_CYC);
    // Sample point lands inside the data cell
    wire [15:0] rx_lag = (rx_per - 16'h1) + ((rx_per - 16'h1) >> 1);
    wire rx_fall = (s2_reg != s3_reg) && !s2_reg;
    wire [19:0] rx_new = {rxsh_reg[18:0], s2_reg};
    wire [3:0] rx_ck = `SCC_CRC_SEED ^ rx_new[19:16] ^ rx_new[15:12] ^
        rx_new[11:8] ^ rx_new[7:4];

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            con_reg <= `SCC_CON1_RST;
            tx_word_reg <= 16'h0000;
            ack_reg <= 1'b0;
            wait_reg <= 1'b1;
            rdata_reg <= 32'h00000000;
        end else begin
            ack_reg <= req;
            wait_reg <= !req;
            if (req) rdata_reg <= rd_mux;
            if (wr_con) con_reg <= avs_writedata[15:0] & `SCC_CON1_MASK;
            if (wr_dat) tx_word_reg <= avs_writedata[15:0];
        end
    end
    assign avs_waitrequest = wait_reg;
    assign avs_readdata = rdata_reg;

    // Trigger flag: set by write or external pulse, cleared by start
    always_ff @(posedge clk) begin
        if (!rst_n) tx_go_reg <= 1'b0;
        else if (wr_dat || (spc_edge && spc_eff)) tx_go_reg <= 1'b1;
        else if (tx_start) tx_go_reg <= 1'b0;
    end

    // Prescaled bit clock
    always_ff @(posedge clk) begin
        if (!rst_n || !run) begin
            tick_reg <= 16'h0;
            pre_reg <= 2'h0;
        end else if (tick_reg == 16'h0) begin
            tick_reg <= 16'(TICK_CYC - 1);
            pre_reg <= (pre_reg == 2'h0) ? pre_max : pre_reg - 2'h1;
        end else begin
            tick_reg <= tick_reg - 16'h1;
        end
    end

    // Transmitter: 20 bits, four data nibbles then checksum nibble
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_reg <= SCC_TX_IDLE;
            nib_reg <= 5'h0;
            rec_reg <= 1'b0;
            sh_reg <= 20'h0;
            out_reg <= 1'b1;
        end else if (!run || rx_mode) begin
            st_reg <= SCC_TX_IDLE;
            out_reg <= rx_mode ? 1'b1 : idle_lvl;
        end else case (st_reg)
            SCC_TX_IDLE: begin
                out_reg <= idle_lvl;
                if (tx_start) begin
                    sh_reg <= {tx_word_reg, crc_on ? tx_ck : 4'h0};
                    nib_reg <= 5'h0;
                    st_reg <= SCC_TX_NIB;
                end
            end
            SCC_TX_NIB: if (tick) begin
                out_reg <= ~idle_lvl;
                rec_reg <= 1'b0;
                st_reg <= SCC_TX_LOW;
            end
            SCC_TX_LOW: if (tick) begin
                if (!rec_reg) begin
                    out_reg <= sh_reg[19] ^ pol_eff;
                    sh_reg <= {sh_reg[18:0], 1'b0};
                    rec_reg <= 1'b1;
                end else begin
                    out_reg <= idle_lvl;
                    nib_reg <= nib_reg + 5'h1;
                    st_reg <= (nib_reg == 5'd19) ? SCC_TX_IDLE : SCC_TX_NIB;
                end
            end
            default: st_reg <= SCC_TX_IDLE;
        endcase
    end
    assign sent_out = out_reg;

    // Pin synchroniser and receiver bit shifter
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s1_reg <= 1'b1;
            s2_reg <= 1'b1;
            s3_reg <= 1'b1;
            sp1_reg <= 1'b0;
            sp2_reg <= 1'b0;
            sp3_reg <= 1'b0;
            rxarm_reg <= 1'b0;
            rxd_reg <= 16'h0;
            rxn_reg <= 5'h0;
            rxsh_reg <= 20'h0;
            rxpush_reg <= 1'b0;
            crcerr_reg <= 1'b0;
        end else begin
            s1_reg <= sent_in;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            sp1_reg <= spc_trigger;
            sp2_reg <= sp1_reg;
            sp3_reg <= sp2_reg;
            rxpush_reg <= 1'b0;
            if (!run || !rx_mode) begin
                rxarm_reg <= 1'b0;
                rxn_reg <= 5'h0;
            end else if (!rxarm_reg) begin
                if (rx_fall) begin
                    rxarm_reg <= 1'b1;
                    rxd_reg <= rx_lag;
                end
            end else if (rxd_reg != 16'h0) begin
                rxd_reg <= rxd_reg - 16'h1;
            end else begin
                rxarm_reg <= 1'b0;
                rxsh_reg <= rx_new;
                rxn_reg <= (rxn_reg == 5'd19) ? 5'h0 : rxn_reg + 5'h1;
                if (rxn_reg == 5'd19) begin
                    rxpush_reg <= buf_rdy;
                    crcerr_reg <= crc_on && (rx_ck != rx_new[3:0]);
                end
            end
        end
    end

    scc_skid #(.WIDTH(16)) u_buf (
        .clk(clk),
        .rst_n(rst_n),
        .in_data(rxsh_reg[19:4]),
        .in_valid(rxpush_reg),
        .in_ready(buf_rdy),
        .out_data(buf_data),
        .out_valid(buf_valid),
        .out_ready(rx_ready)
    );
    assign rx_data = buf_data;
    assign rx_valid = buf_valid;
    assign crc_error = crcerr_reg;
endmodule // scc_channel

// [testbench/scc_chk.sv]
// Port checker for the channel control block
module scc_chk (
    // Clock and bus
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    // Device and link
    input wire logic idle_mode,
    input wire logic sent_out,
    input wire logic rx_valid,
    input wire logic crc_error
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] con_reg;
    wire ack = !avs_waitrequest && (avs_read || avs_write);
    wire rd0 = ack && avs_read && avs_address == 4'h0;
    wire rd_un = ack && avs_read &&
        !(avs_address inside {4'h0, 4'h4, 4'h8});
    wire halt = idle_mode && con_reg[13];
    // Shadow of the control word
    always_ff @(posedge clk)
        if (!rst_n) con_reg <= 16'h0000;
        else if (ack && avs_write && avs_address == 4'h0)
            con_reg <= avs_writedata[15:0];
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    property p_mask; rd0 |-> (avs_readdata & 32'hFFFF5028) == 0; endproperty
    a_mask: assert property (p_mask) else $error("reserved bits set");
    property p_unmap; rd_un |-> avs_readdata == 32'h0; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read");
    property p_ack; (avs_read || avs_write) && avs_waitrequest
        |=> !avs_waitrequest; endproperty
    a_ack: assert property (p_ack) else $error("late answer");
    property p_one; !avs_waitrequest |=> avs_waitrequest; endproperty
    a_one: assert property (p_one) else $error("answer too long");
    property p_rxpin; con_reg[11] && $past(con_reg[11], 2) |-> $stable(sent_out);
    endproperty
    a_rxpin: assert property (p_rxpin) else $error("pin moved");
    property p_halt; halt && $past(halt, 2) |-> $stable(sent_out); endproperty
    a_halt: assert property (p_halt) else $error("ran in idle");
    property p_txrx; !con_reg[11] && !$past(con_reg[11], 2) && !$past(rx_valid)
        |-> !rx_valid; endproperty
    a_txrx: assert property (p_txrx) else $error("rx in tx");
    property p_crc; $rose(crc_error) |-> con_reg[8] && con_reg[11]; endproperty
    a_crc: assert property (p_crc) else $error("crc flag");
    c_wr: cover property (ack && avs_write);
    c_halt: cover property (halt);
    c_edge: cover property ($fell(sent_out));
    c_rx: cover property (rx_valid);
endmodule // scc_chk

// [testbench/scc_far.sv]
// Far-side model: line pulled up, counts pin edges
module scc_far (
    input wire logic clk,
    input wire logic sent_out,
    output logic sent_in,
    output int edges,
    output logic [19:0] got
);
    timeunit 1ns;
    timeprecision 1ps;
    logic last;
    logic fall;
    initial sent_in = 1'b1;
    initial edges = 0;
    // Counts edges and captures data cells after each marker
    always @(posedge clk) begin
        if (sent_out !== last) edges <= edges + 1;
        last <= sent_out;
        fall <= (last === 1'b1) && (sent_out === 1'b0);
        if (fall === 1'b1) got <= {got[18:0], sent_out};
    end
    // Sends one frame: marker, data, recovery, one clock each
    task automatic send(input logic [19:0] bits);
        for (int i = 19; i >= 0; i--) begin
            sent_in <= 1'b0;
            @(posedge clk);
            sent_in <= bits[i];
            @(posedge clk);
            sent_in <= 1'b1;
            @(posedge clk);
        end
    endtask
endmodule // scc_far

// [testbench/sent_channel_control_config_test.sv]
// Testbench for the channel control block
`include "scc_cfg.svh"
module sent_channel_control_config_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, rst_n = 0, rd = 0, wr = 0, idle = 0, spc = 0, rdy = 1;
    logic [3:0] adr = 4'h0;
    logic [31:0] wd = 32'h0, rdat, q;
    logic sin, sout, rxv, crc, wreq;
    logic [15:0] rxd;
    logic [19:0] got;
    int edges, e0, n_mismatch = 0, compares = 0;
    always #12.5 clk = ~clk;
    scc_channel #(.TICK_CYC(1)) u_scc_channel (.clk(clk), .rst_n(rst_n),
        .avs_address(adr), .avs_read(rd), .avs_write(wr),
        .avs_writedata(wd), .avs_readdata(rdat), .avs_waitrequest(wreq),
        .idle_mode(idle), .spc_trigger(spc), .sent_in(sin), .sent_out(sout),
        .rx_data(rxd), .rx_valid(rxv), .rx_ready(rdy), .crc_error(crc));
    scc_far u_scc_far (.clk(clk), .sent_out(sout), .sent_in(sin),
        .edges(edges), .got(got));
    function automatic logic [3:0] ck4(input logic [15:0] w);
        return `SCC_CRC_SEED ^ w[15:12] ^ w[11:8] ^ w[7:4] ^ w[3:0];
    endfunction
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR %0t seen %h want %h", $time, seen, exp);
        end
    endtask
    task bus(input logic w, input logic [3:0] a, input logic [15:0] d);
        int n;
        n = 0;
        adr <= a; wr <= w; rd <= !w; wd <= {16'h0000, d};
        do begin @(posedge clk); n++; end while (wreq !== 1'b0 && n < 50);
        if (n >= 50) n_mismatch++;
        q = rdat;
        rd <= 1'b0; wr <= 1'b0;
        @(posedge clk);
    endtask
    task t_regs;
        bus(1, 4'h0, 16'hFFFF); bus(0, 4'h0, 16'h0); chk(q, 32'h0000AFD7);
        bus(0, 4'hC, 16'h0); chk(q, 32'h0);
    endtask
    task t_pol;
        bus(1, 4'h0, 16'h8400); repeat (4) @(posedge clk); chk(sout, 1);
        bus(1, 4'h0, 16'h8600); repeat (4) @(posedge clk); chk(sout, 0);
        bus(1, 4'h0, 16'h8E00); repeat (4) @(posedge clk); chk(sout, 1);
    endtask
    task t_idle;
        bus(1, 4'h0, 16'hA400); idle <= 1'b1; e0 = edges;
        bus(1, 4'h4, 16'h1234); repeat (200) @(posedge clk);
        chk(edges - e0, 0);
        bus(1, 4'h0, 16'h8400); repeat (300) @(posedge clk);
        chk(edges > e0, 1);
        e0 = edges; bus(1, 4'h4, 16'h5A5A); repeat (300) @(posedge clk);
        chk(edges > e0, 1);
        idle <= 1'b0;
    endtask
    task t_tx;
        bus(1, 4'h0, 16'h8500); bus(1, 4'h4, 16'h9C61);
        repeat (100) @(posedge clk);
        chk(got, {16'h9C61, ck4(16'h9C61)});
        bus(1, 4'h0, 16'h8400); bus(1, 4'h4, 16'h9C61);
        repeat (100) @(posedge clk);
        chk(got, {16'h9C61, 4'h0});
    endtask
    task t_spc;
        bus(1, 4'h0, 16'h8440); e0 = edges;
        spc <= 1'b1; @(posedge clk); spc <= 1'b0;
        repeat (100) @(posedge clk); chk(edges - e0, 0);
        bus(0, 4'h8, 16'h0); chk(q[1], 0);
        bus(1, 4'h0, 16'h8840);
        spc <= 1'b1; @(posedge clk); spc <= 1'b0;
        repeat (10) @(posedge clk);
        bus(0, 4'h8, 16'h0); chk(q[1], 1);
    endtask
    task t_rx;
        bus(1, 4'h0, 16'h8900); rdy <= 1'b0;
        u_scc_far.send({16'hC3A5, ck4(16'hC3A5)});
        u_scc_far.send({16'h1234, ~ck4(16'h1234)});
        repeat (8) @(posedge clk);
        chk(rxv, 1);
        chk(rxd, 16'hC3A5);
        chk(crc, 1);
        rdy <= 1'b1; @(posedge clk); rdy <= 1'b0; @(negedge clk);
        chk(rxd, 16'h1234);
        @(posedge clk); rdy <= 1'b1;
        repeat (2) @(posedge clk); rdy <= 1'b0;
        bus(1, 4'h0, 16'h8800);
        u_scc_far.send({16'h0F0F, ~ck4(16'h0F0F)});
        repeat (8) @(posedge clk);
        chk(rxv, 1);
        chk(rxd, 16'h0F0F);
        chk(crc, 0);
        rdy <= 1'b1;
    endtask
    task wrap_up;
        $display("mismatches %0d compares %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        t_regs; t_pol; t_idle; t_tx; t_spc; t_rx;
        wrap_up;
    end
    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        wrap_up;
    end
endmodule // sent_channel_control_config_test
bind scc_channel scc_chk u_scc_chk (.clk(clk), .rst_n(rst_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .idle_mode(idle_mode),
    .sent_out(sent_out), .rx_valid(rx_valid), .crc_error(crc_error));
